// [dv/spm_link_sva.sv]
// assertions on the bit-slot link between host and device
`timescale 1ns/100ps
`default_nettype none
module spm_link_sva
	import spm_pkg::*;
#(
	parameter int RST_STD = RST_STD_CYC,
	parameter int RST_OD  = RST_OD_CYC,
	parameter int SLOT_OD = SLOT_OD_CYC
)(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// link signals
	input  wire logic bus_rst,
	input  wire logic slot,
	input  wire logic wbit,
	input  wire logic od,
	input  wire logic done,
	input  wire logic rbit
);
	// -----------------------------------------------------------------
	// helper counters
	// -----------------------------------------------------------------
	localparam int SLACK = 2;
	int            gap_ff;
	int            rlen_ff;
	logic          pend_ff;
	// cycles since done, bus reset length, slot awaiting answer
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			gap_ff  <= 100000;
			rlen_ff <= 0;
			pend_ff <= 1'b0;
		end
		else
		begin
			gap_ff  <= done ? 0 : ((gap_ff < 100000) ? gap_ff + 1 : gap_ff);
			rlen_ff <= bus_rst ? rlen_ff + 1 : 0;
			pend_ff <= (slot && !bus_rst) ? 1'b1 : (done ? 1'b0 : pend_ff);
		end
	end
	// -----------------------------------------------------------------
	// properties
	// -----------------------------------------------------------------
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	slot_answer_a:
	assert property (slot && !bus_rst |-> ##[2:900] done) else $error("slot not answered");
	done_cause_a:
	assert property (done |-> pend_ff) else $error("answer without slot");
	done_pulse_a:
	assert property (done |=> !done) else $error("answer longer than one cycle");
	one_pend_a:
	assert property (slot |-> !pend_ff) else $error("slot while one is pending");
	no_slot_rst_a:
	assert property (bus_rst |-> !slot) else $error("slot during bus reset");
	rst_len_a:
	assert property ($fell(bus_rst) |-> rlen_ff == (od ? RST_OD : RST_STD)) else $error("bus reset length");
	slot_gap_a:
	assert property (slot |-> gap_ff + SLACK >= (od ? SLOT_OD : SLOT_STD_CYC)) else $error("slot gap short");
	rbit_hold_a:
	assert property (!done |-> $stable(rbit)) else $error("line bit moved between answers");
	rbit_line_a:
	assert property (done && !wbit |-> !rbit) else $error("line bit high on a zero slot");
	wbit_hold_a:
	assert property (slot |=> $stable(wbit) ##1 $stable(wbit)) else $error("slot bit moved");
	od_default_a:
	assert property ($rose(rst_n_i) |-> !od) else $error("overdrive after reset");
endmodule
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench: host and device joined over the link
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("Error %0t: got %h want %h", $time, g, e); end end
module testbench;
	import spm_pkg::*;
	localparam int RST_SIM = 50;
	localparam int GAP_SIM = 40;                                     // short slot gap keeps the run brief
	// -----------------------------------------------------------------
	// signals and model state
	// -----------------------------------------------------------------
	logic        clk_i       = 1'b0;
	logic        rst_n_i     = 1'b0;
	logic        cyc         = 1'b0;
	logic        stb         = 1'b0;
	logic        we          = 1'b0;
	logic [3:0]  adr         = 4'h0;
	logic [31:0] wdat        = 32'h0000_0000;
	logic        busy        = 1'b0;
	logic        mact        = 1'b0;
	logic [63:0] pw          = 64'h0000_0000_0000_0000;
	logic [31:0] lf          = 32'h0000_6D80;
	logic [31:0] rdat;
	logic        ack;
	logic        mwe;
	logic [15:0] maddr;
	logic [7:0]  mdat;
	logic [15:0] ta;
	logic [7:0]  es;
	logic        ods;
	logic [15:0] crc;
	logic [7:0]  r;
	logic [7:0]  d0;
	logic [31:0] s;
	logic [23:0] mq[$];
	logic [7:0]  q[$];
	int          n_fail      = 0;
	int          check_count = 0;
	// -----------------------------------------------------------------
	// design, link and checker
	// -----------------------------------------------------------------
	spm_link_if link_if ();
	spm_host #(.RST_STD(RST_SIM), .RST_OD(RST_SIM), .SLOT_OD(GAP_SIM)) spm_host_inst (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .link(link_if));
	spm_device spm_device_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_if), .mission_active_i(mact),
		.pw_check_en_i(1'b1), .full_pw_i(pw), .mem_busy_i(busy), .mem_we_o(mwe), .mem_addr_o(maddr),
		.mem_wdata_o(mdat), .target_addr_o(ta), .end_status_byte_o(es), .overdrive_select_o(ods));
	spm_link_sva #(.RST_STD(RST_SIM), .RST_OD(RST_SIM), .SLOT_OD(GAP_SIM)) spm_link_sva_inst (.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.bus_rst(link_if.bus_rst), .slot(link_if.slot), .wbit(link_if.wbit), .od(link_if.od),
		.done(link_if.done), .rbit(link_if.rbit));
	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] v;
		v = c;
		for (int i = 0; i < 8; i++)
			v = (v[0] ^ b[i]) ? ((v >> 1) ^ CRC_POLY) : (v >> 1);
		return v;
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic bound(input int t, input int lim);
		if (t >= lim)
		begin
			n_fail++;
			summarize();
		end
	endtask
	// one classic wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int t;
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		t = 0;
		do
		begin
			@(posedge clk_i);
			t++;
		end
		while (ack !== 1'b1 && t < 20);
		bound(t, 20);
		s = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	// issue a link command word and poll until idle
	task automatic xfer(input logic [12:0] c);
		int t;
		wb(1'b1, WB_CMD_OFF, {19'h0_0000, c});
		t = 0;
		do
		begin
			wb(1'b0, WB_STAT_OFF, 32'h0000_0000);
			t++;
		end
		while (s[STAT_BUSY_BIT] !== 1'b0 && t < 5000);
		bound(t, 5000);
		r = s[15:8];
	endtask
	task automatic snd(input logic [7:0] b);
		xfer({5'h00, b});
		crc = crc8(crc, b);
	endtask
	// inverted crc, low byte first
	task automatic crc_chk();
		logic [15:0] x;
		x = ~crc;
		xfer(13'h00FF);
		`CHK(r, x[7:0])
		xfer(13'h00FF);
		`CHK(r, x[15:8])
	endtask
	// -----------------------------------------------------------------
	// clock, random stall, copy write monitor
	// -----------------------------------------------------------------
	initial
		forever #10 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		lf   <= lfsr(lf);
		busy <= lf[0] & lf[2];
	end
	always @(posedge clk_i)
		if (mwe === 1'b1)
			`CHK({maddr, mdat}, (mq.size() > 0) ? mq.pop_front() : 24'h00_0000)
	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		wb(1'b0, WB_STAT_OFF, 32'h0000_0000);
		`CHK(s[STAT_OD_BIT], OD_RESET)
		wb(1'b1, WB_CTRL_OFF, 32'h0000_0001);
		wb(1'b0, WB_STAT_OFF, 32'h0000_0000);
		`CHK(s[STAT_OD_BIT], 1'b1)
		`CHK(ods, 1'b1)
		d0 = lf[15:8];
		pw <= {lf, ~lf};
		// write one byte at offset 1Fh
		crc = 16'h0000;
		q = '{CMD_WRITE_SP, 8'h3F, 8'h01, d0};
		foreach (q[i])
			snd(q[i]);
		crc_chk();
		`CHK(ta, 16'h013F)
		`CHK(es, 8'h1F)
		// read back after a bus reset
		xfer(13'h1000);
		crc = 16'h0000;
		snd(CMD_READ_SP);
		q = '{8'h3F, 8'h01, 8'h1F, d0};
		foreach (q[i])
		begin
			xfer(13'h00FF);
			`CHK(r, q[i])
			crc = crc8(crc, q[i]);
		end
		crc_chk();
		xfer(13'h00FF);
		`CHK(r, 8'hFF)
		// copy with the right password, then with a wrong one
		mq.push_back({16'h013F, d0});
		for (int k = 0; k < 2; k++)
		begin
			xfer(13'h1000);
			q = '{CMD_COPY_SP, 8'h3F, 8'h01, {k[0], 7'h1F}};
			foreach (q[i])
				snd(q[i]);
			for (int i = 0; i < 8; i++)
				snd(pw[8*i +: 8] ^ {7'h00, k[0]});
			xfer(13'h00FF);
			`CHK(r, k ? 8'hFF : 8'h55)
			`CHK(es, 8'h9F)
			`CHK(mq.size() == 0, 1'b1)
		end
		// overfill, then a partial byte
		xfer(13'h1000);
		q = '{CMD_WRITE_SP, 8'h1F, 8'h00, ~d0, 8'h11};
		foreach (q[i])
			snd(q[i]);
		`CHK(es, 8'h1F)
		xfer(13'h0305);
		xfer(13'h1000);
		`CHK(es, 8'h3F)
		`CHK(ta, 16'h001F)
		// register page copy refused while a mission runs
		mact <= 1'b1;
		q = '{CMD_WRITE_SP, 8'h1F, 8'h02, d0, CMD_COPY_SP, 8'h1F, 8'h02, 8'h1F};
		foreach (q[i])
		begin
			if (i == 4)
				xfer(13'h1000);
			snd(q[i]);
		end
		for (int i = 0; i < 8; i++)
			snd(pw[8*i +: 8]);
		xfer(13'h00FF);
		`CHK(r, 8'hFF)
		`CHK(es, 8'h1F)
		`CHK(mq.size() == 0, 1'b1)
		summarize();
	end
endmodule
`default_nettype wire

// [rtl/spm_crc16.sv]
// bit-serial crc-16 generator, lsb first
`timescale 1ns/100ps
`default_nettype none
module spm_crc16
	import spm_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// control
	input  wire logic        clr_i,
	input  wire logic        en_i,
	input  wire logic        bit_i,
	// result
	output logic [15:0]      crc_o
);
	typedef struct packed {
		logic [15:0] crc;
	} spm_crc_s;

	spm_crc_s st_ff;
	spm_crc_s nxt_st;
	logic     fb;

	// clear wins over shift
	always_comb
	begin
		nxt_st = st_ff;
		fb     = bit_i ^ st_ff.crc[0];
		if (clr_i)
			nxt_st.crc = 16'h0000;
		else if (en_i)
			nxt_st.crc = {1'b0, st_ff.crc[15:1]} ^ (fb ? CRC_POLY : 16'h0000);
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign crc_o = st_ff.crc;
endmodule
`default_nettype wire

// [rtl/spm_device.sv]
// scratchpad device end: write, read and copy scratchpad over the bit-slot link
`timescale 1ns/100ps
`default_nettype none
module spm_device
	import spm_pkg::*;
#(
	parameter logic [15:0] REG_BASE = REG_PAGE_BASE,
	parameter logic [15:0] REG_END  = REG_PAGE_END
)(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// link
	spm_link_if.dev          link,
	// device state and secrets
	input  wire logic        mission_active_i,
	input  wire logic        pw_check_en_i,
	input  wire logic [63:0] full_pw_i,
	// memory write port
	input  wire logic        mem_busy_i,
	output logic             mem_we_o,
	output logic [15:0]      mem_addr_o,
	output logic [7:0]       mem_wdata_o,
	// status
	output logic [15:0]      target_addr_o,
	output logic [7:0]       end_status_byte_o,
	output logic             overdrive_select_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		spm_dev_e        state;
		logic [15:0]     ta;
		logic [4:0]      es_end;
		logic            pf;
		logic            aa;
		logic [31:0][7:0] sp;
		logic [7:0]      sh;
		logic [3:0]      nbit;
		logic [4:0]      boff;
		logic [1:0]      bcnt;
		logic [7:0]      txb;
		logic [63:0]     pw;
		logic            auth_ok;
		logic            pend;
		logic            done;
		logic            rbit;
		logic            alt;
		logic [7:0]      cnt;
		logic            mem_we;
		logic [15:0]     mem_addr;
		logic [7:0]      mem_wdata;
		logic            rst_q;
		logic            od;
	} spm_dev_s;

	spm_dev_s    st_ff;
	spm_dev_s    nxt_st;
	logic [15:0] crc;
	logic        crc_clr;
	logic        crc_en;
	logic        dbit;
	logic        line;
	logic        act;
	logic        rst_rise;
	logic        byte_done;
	logic [7:0]  rx;
	logic [7:0]  es_byte;
	logic [7:0]  auth_ref;
	logic [63:0] pw_full;
	logic        reg_page;

	// ----------------------------------------------------------------
	// crc generator
	// ----------------------------------------------------------------
	spm_crc16 u_crc (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.clr_i   (crc_clr),
		.en_i    (crc_en),
		.bit_i   (line),
		.crc_o   (crc)
	);

	// status byte and link helpers
	assign es_byte   = {st_ff.aa, 1'b0, st_ff.pf, st_ff.es_end};
	assign rst_rise  = link.bus_rst & ~st_ff.rst_q;
	assign act       = st_ff.pend & ~link.bus_rst & (st_ff.state != D_COPY);
	assign line      = link.wbit & dbit;
	assign rx        = {line, st_ff.sh[7:1]};
	assign byte_done = act & (st_ff.nbit[2:0] == 3'd7);
	assign pw_full   = {line, st_ff.pw[63:1]};
	assign reg_page  = (st_ff.ta >= REG_BASE) && (st_ff.ta <= REG_END);
	assign crc_clr   = rst_rise && (st_ff.state != D_COPY);
	assign crc_en    = act && ((st_ff.state == D_IDLE) || (st_ff.state == D_WADDR) || (st_ff.state == D_WDATA)
	                   || (st_ff.state == D_RPRE) || (st_ff.state == D_RDATA));

	// bit the device puts on the line in this slot
	always_comb
	begin
		case (st_ff.state)
			D_RPRE, D_RDATA: dbit = st_ff.txb[0];
			D_WCRC, D_RCRC:  dbit = ~crc[st_ff.nbit];
			D_ALT:           dbit = st_ff.alt;
			default:         dbit = 1'b1;
		endcase
	end

	// authorization byte expected at each pattern position
	always_comb
	begin
		case (st_ff.bcnt)
			2'd0:    auth_ref = st_ff.ta[7:0];
			2'd1:    auth_ref = st_ff.ta[15:8];
			default: auth_ref = es_byte;
		endcase
	end

	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_st        = st_ff;
		nxt_st.rst_q  = link.bus_rst;
		nxt_st.od     = link.od;
		nxt_st.done   = act;
		nxt_st.mem_we = 1'b0;
		if (link.slot)
			nxt_st.pend = 1'b1;
		if (act)
		begin
			nxt_st.pend = 1'b0;
			nxt_st.rbit = line;
			nxt_st.sh   = rx;
			nxt_st.nbit = st_ff.nbit + 4'd1;
			nxt_st.txb  = {1'b1, st_ff.txb[7:1]};
		end
		if (rst_rise && (st_ff.state != D_COPY))
		begin
			// stray bits after the last whole byte, also past offset 1Fh
			if (((st_ff.state == D_WDATA) || (st_ff.state == D_WCRC)) && (st_ff.nbit[2:0] != 3'd0))
				nxt_st.pf = 1'b1;
			nxt_st.state = D_IDLE;
			nxt_st.nbit  = 4'd0;
			nxt_st.pend  = 1'b0;
		end
		else
		begin
			case (st_ff.state)
				D_IDLE:
				begin
					if (byte_done)
					begin
						nxt_st.nbit = 4'd0;
						nxt_st.bcnt = 2'd0;
						case (rx)
							CMD_WRITE_SP:
							begin
								nxt_st.state = D_WADDR;
								nxt_st.aa    = 1'b0;
								nxt_st.pf    = 1'b0;
							end
							CMD_READ_SP:
							begin
								nxt_st.state = D_RPRE;
								nxt_st.txb   = st_ff.ta[7:0];
								nxt_st.boff  = st_ff.ta[4:0];
							end
							CMD_COPY_SP:
							begin
								nxt_st.state   = D_CAUTH;
								nxt_st.auth_ok = 1'b1;
							end
							default: nxt_st.state = D_HALT;
						endcase
					end
				end
				D_WADDR:
				begin
					if (byte_done)
					begin
						nxt_st.nbit = 4'd0;
						nxt_st.bcnt = st_ff.bcnt + 2'd1;
						if (st_ff.bcnt == 2'd0)
							nxt_st.ta[7:0] = rx;
						else
						begin
							nxt_st.ta[15:8] = rx;
							nxt_st.boff     = st_ff.ta[4:0];
							nxt_st.state    = D_WDATA;
						end
					end
				end
				D_WDATA:
				begin
					if (byte_done)
					begin
						nxt_st.nbit           = 4'd0;
						nxt_st.sp[st_ff.boff] = rx;
						nxt_st.es_end         = st_ff.boff;
						if (st_ff.boff == SP_LAST_OFF)
							nxt_st.state = D_WCRC;
						else
							nxt_st.boff = st_ff.boff + 5'd1;
					end
				end
				D_RPRE:
				begin
					if (byte_done)
					begin
						nxt_st.nbit = 4'd0;
						nxt_st.bcnt = st_ff.bcnt + 2'd1;
						case (st_ff.bcnt)
							2'd0:    nxt_st.txb = st_ff.ta[15:8];
							2'd1:    nxt_st.txb = es_byte;
							default:
							begin
								nxt_st.txb   = st_ff.sp[st_ff.boff];
								nxt_st.state = D_RDATA;
							end
						endcase
					end
				end
				D_RDATA:
				begin
					if (byte_done)
					begin
						nxt_st.nbit = 4'd0;
						if (st_ff.boff == SP_LAST_OFF)
							nxt_st.state = D_RCRC;
						else
						begin
							nxt_st.boff = st_ff.boff + 5'd1;
							nxt_st.txb  = st_ff.sp[5'(st_ff.boff + 5'd1)];
						end
					end
				end
				D_WCRC, D_RCRC:
				begin
					if (act && (st_ff.nbit == 4'd15))
						nxt_st.state = D_ONES;
				end
				D_CAUTH:
				begin
					if (byte_done)
					begin
						nxt_st.nbit = 4'd0;
						nxt_st.bcnt = st_ff.bcnt + 2'd1;
						if (rx != auth_ref)
							nxt_st.auth_ok = 1'b0;
						if (st_ff.bcnt == 2'd2)
						begin
							nxt_st.state = D_CPASS;
							nxt_st.bcnt  = 2'd0;
						end
					end
				end
				D_CPASS:
				begin
					if (act)
						nxt_st.pw = pw_full;
					if (act && (st_ff.nbit == 4'd15) && (st_ff.bcnt == 2'd3))
					begin
						nxt_st.nbit = 4'd0;
						if (pw_check_en_i && (pw_full != full_pw_i))
							nxt_st.state = D_HALT;
						else if (!st_ff.auth_ok || (st_ff.es_end != SP_LAST_OFF) || (mission_active_i && reg_page))
							nxt_st.state = D_HALT;
						else
						begin
							nxt_st.aa       = 1'b1;
							nxt_st.state    = D_COPY;
							nxt_st.boff     = st_ff.ta[4:0];
							nxt_st.mem_addr = st_ff.ta;
							nxt_st.cnt      = 8'd0;
						end
					end
					else if (act && (st_ff.nbit == 4'd15))
						nxt_st.bcnt = st_ff.bcnt + 2'd1;
				end
				D_COPY:
				begin
					if (st_ff.cnt != 8'(COPY_CYC - 1))
						nxt_st.cnt = st_ff.cnt + 8'd1;
					else if (!mem_busy_i)
					begin
						nxt_st.mem_we    = 1'b1;
						nxt_st.mem_wdata = st_ff.sp[st_ff.boff];
						nxt_st.mem_addr  = st_ff.mem_addr;
						nxt_st.cnt       = 8'd0;
						if (st_ff.boff == st_ff.es_end)
						begin
							nxt_st.state = D_ALT;
							nxt_st.alt   = 1'b1;
						end
						else
							nxt_st.boff = st_ff.boff + 5'd1;
					end
				end
				D_ALT:
				begin
					if (act)
						nxt_st.alt = ~st_ff.alt;
				end
				default: ;
			endcase
		end
		// address advances after each copied byte
		if (st_ff.mem_we)
			nxt_st.mem_addr = st_ff.mem_addr + 16'd1;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign link.done          = st_ff.done;
	assign link.rbit          = st_ff.rbit;
	assign mem_we_o           = st_ff.mem_we;
	assign mem_addr_o         = st_ff.mem_addr;
	assign mem_wdata_o        = st_ff.mem_wdata;
	assign target_addr_o      = st_ff.ta;
	assign end_status_byte_o  = es_byte;
	assign overdrive_select_o = st_ff.od;
endmodule
`default_nettype wire

// [rtl/spm_host.sv]
// bus master end: wishbone-driven byte and reset sequencer for the bit-slot link
`timescale 1ns/100ps
`default_nettype none
module spm_host
	import spm_pkg::*;
#(
	parameter int RST_STD = RST_STD_CYC,
	parameter int RST_OD  = RST_OD_CYC,
	parameter int SLOT_OD = SLOT_OD_CYC
)(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// link
	spm_link_if.host         link
);
	typedef struct packed {
		spm_host_e   state;
		logic        od;
		logic [15:0] cnt;
		logic [7:0]  txb;
		logic [3:0]  nleft;
		logic [7:0]  rxb;
		logic        bus_rst;
		logic        slot;
		logic        wbit;
		logic        ack;
		logic [31:0] rdat;
	} spm_host_s;

	spm_host_s   st_ff;
	spm_host_s   nxt_st;
	logic        req;
	logic        wr;
	logic [15:0] gap;

	assign req = wb_cyc_i & wb_stb_i;
	assign wr  = req & wb_we_i & st_ff.ack;
	assign gap = st_ff.od ? 16'(SLOT_OD) : 16'(SLOT_STD_CYC);

	// ----------------------------------------------------------------
	// register access and link sequencing
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_st      = st_ff;
		nxt_st.ack  = req & ~st_ff.ack;
		nxt_st.slot = 1'b0;
		// read data captured when the answer is raised
		if (req && !st_ff.ack)
		begin
			case (wb_adr_i)
				WB_CTRL_OFF: nxt_st.rdat = {31'h0000_0000, st_ff.od};
				WB_STAT_OFF: nxt_st.rdat = {16'h0000, st_ff.rxb, 6'h00, st_ff.od, st_ff.state != H_IDLE};
				default:     nxt_st.rdat = 32'h0000_0000;
			endcase
		end
		// control register: speed select
		if (wr && (wb_adr_i == WB_CTRL_OFF) && wb_sel_i[0])
			nxt_st.od = wb_dat_i[CTRL_OD_BIT];
		case (st_ff.state)
			H_IDLE:
			begin
				if (wr && (wb_adr_i == WB_CMD_OFF) && (wb_sel_i[1:0] == 2'b11))
				begin
					if (wb_dat_i[CMD_RST_BIT])
					begin
						nxt_st.state   = H_RST;
						nxt_st.bus_rst = 1'b1;
						nxt_st.cnt     = st_ff.od ? 16'(RST_OD) : 16'(RST_STD);
					end
					else
					begin
						nxt_st.state = H_SLOT;
						nxt_st.txb   = wb_dat_i[7:0];
						nxt_st.nleft = (wb_dat_i[11:8] == 4'd0 || wb_dat_i[11:8] > 4'd8) ? 4'd8 : wb_dat_i[11:8];
					end
				end
			end
			H_RST:
			begin
				nxt_st.cnt = st_ff.cnt - 16'd1;
				if (st_ff.cnt == 16'd1)
				begin
					nxt_st.bus_rst = 1'b0;
					nxt_st.nleft   = 4'd0;
					nxt_st.cnt     = gap;
					nxt_st.state   = H_GAP;
				end
			end
			H_SLOT:
			begin
				nxt_st.slot  = 1'b1;
				nxt_st.wbit  = st_ff.txb[0];
				nxt_st.state = H_WAIT;
			end
			H_WAIT:
			begin
				if (link.done)
				begin
					nxt_st.rxb   = {link.rbit, st_ff.rxb[7:1]};
					nxt_st.txb   = {1'b1, st_ff.txb[7:1]};
					nxt_st.nleft = st_ff.nleft - 4'd1;
					nxt_st.cnt   = gap;
					nxt_st.state = H_GAP;
				end
			end
			H_GAP:
			begin
				nxt_st.cnt = st_ff.cnt - 16'd1;
				if (st_ff.cnt <= 16'd1)
					nxt_st.state = (st_ff.nleft != 4'd0) ? H_SLOT : H_IDLE;
			end
			default: nxt_st.state = H_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			st_ff      <= '0;
			st_ff.od   <= OD_RESET;
			st_ff.wbit <= 1'b1;
		end
		else
			st_ff <= nxt_st;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign wb_dat_o     = st_ff.rdat;
	assign wb_ack_o     = st_ff.ack;
	assign link.bus_rst = st_ff.bus_rst;
	assign link.slot    = st_ff.slot;
	assign link.wbit    = st_ff.wbit;
	assign link.od      = st_ff.od;
endmodule
`default_nettype wire

// [rtl/spm_link_if.sv]
// bit-slot link between the bus master and the scratchpad device
`timescale 1ns/100ps
`default_nettype none
interface spm_link_if;
	logic bus_rst;   // bus reset level, master driven
	logic slot;      // one-cycle slot request
	logic wbit;      // master bit, 1 on read slots
	logic od;        // overdrive select
	logic done;      // one-cycle slot answer
	logic rbit;      // resolved line bit of the slot

	modport host (output bus_rst, output slot, output wbit, output od, input done, input rbit);
	modport dev  (input bus_rst, input slot, input wbit, input od, output done, output rbit);
endinterface
`default_nettype wire

// [rtl/spm_pkg.sv]
// shared constants and types of the scratchpad memory access link
package spm_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int          CLK_MHZ         = 50;
	localparam int          COPY_NS_BYTE    = 2000;                      // copy time per byte
	localparam int          COPY_CYC        = COPY_NS_BYTE * CLK_MHZ / 1000;
	localparam int          RST_STD_US      = 480;                       // bus reset pulse, standard
	localparam int          RST_OD_US       = 48;                        // bus reset pulse, overdrive
	localparam int          RST_STD_CYC     = RST_STD_US * CLK_MHZ;
	localparam int          RST_OD_CYC      = RST_OD_US * CLK_MHZ;
	localparam int          SLOT_STD_US     = 60;                        // slot spacing, standard
	localparam int          SLOT_OD_US      = 8;                         // slot spacing, overdrive
	localparam int          SLOT_STD_CYC    = SLOT_STD_US * CLK_MHZ;
	localparam int          SLOT_OD_CYC     = SLOT_OD_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// commands, status byte layout, memory map
	// ----------------------------------------------------------------
	localparam logic [7:0]  CMD_WRITE_SP    = 8'h0F;
	localparam logic [7:0]  CMD_READ_SP     = 8'hAA;
	localparam logic [7:0]  CMD_COPY_SP     = 8'h99;
	localparam int          ES_AA_BIT       = 7;
	localparam int          ES_ZERO_BIT     = 6;
	localparam int          ES_PF_BIT       = 5;
	localparam logic [4:0]  SP_LAST_OFF     = 5'h1F;
	localparam logic [15:0] CRC_POLY        = 16'hA001;                  // reflected crc-16
	localparam logic [15:0] REG_PAGE_BASE   = 16'h0200;
	localparam logic [15:0] REG_PAGE_END    = 16'h023F;

	// ----------------------------------------------------------------
	// host wishbone register map and fields
	// ----------------------------------------------------------------
	localparam logic [3:0]  WB_CTRL_OFF     = 4'h0;
	localparam logic [3:0]  WB_CMD_OFF      = 4'h4;
	localparam logic [3:0]  WB_STAT_OFF     = 4'h8;
	localparam int          CTRL_OD_BIT     = 0;
	localparam int          CMD_RST_BIT     = 12;
	localparam int          STAT_BUSY_BIT   = 0;
	localparam int          STAT_OD_BIT     = 1;
	localparam logic        OD_RESET        = 1'b0;

	// ----------------------------------------------------------------
	// state enumerations
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		D_IDLE, D_WADDR, D_WDATA, D_WCRC, D_RPRE, D_RDATA, D_RCRC,
		D_ONES, D_CAUTH, D_CPASS, D_COPY, D_ALT, D_HALT
	} spm_dev_e;

	typedef enum logic [2:0] {
		H_IDLE, H_RST, H_SLOT, H_WAIT, H_GAP
	} spm_host_e;

endpackage
